// *** pc_stack_pkg.sv ***
// constants and types shared by the program-flow and indirect-address block
package pc_stack_pkg;
  localparam int PC_WIDTH        = 13;
  localparam int LATCH_WIDTH     = 5;
  localparam int STACK_DEPTH     = 8;
  localparam int STACK_PTR_WIDTH = 3;
  localparam int ADDR_WIDTH      = 9;
  localparam logic [12:0] PC_RESET        = 13'h0000;
  localparam logic [4:0]  LATCH_RESET     = 5'h00;
  localparam logic [7:0]  POINTER_RESET   = 8'h00;
  localparam logic [7:0]  INDIRECT_REG_ADDR = 8'h00;
  localparam logic [7:0]  READ_SELF_VALUE = 8'h00;

  typedef enum logic [2:0] {
    PC_HOLD,
    PC_STEP,
    PC_WRITE_LOW,
    PC_CALL,
    PC_JUMP,
    PC_VECTOR,
    PC_RETURN
  } pc_op_type;
endpackage : pc_stack_pkg

// *** return_stack_mem.sv ***
// eight-entry circular return stack memory with registered read data
`timescale 1ns/1ps
module return_stack_mem
  import pc_stack_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_WIDTH
)
(
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       wr_en,
  input  wire logic [STACK_PTR_WIDTH-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]           wr_data,
  input  wire logic [STACK_PTR_WIDTH-1:0] rd_addr,
  output logic      [WIDTH-1:0]           rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_data_d;

  // read data is the entry the next pop would take
  always_comb
  begin
    rd_data_d = mem_q[rd_addr];
    if (wr_en && (wr_addr == rd_addr))
    begin
      rd_data_d = wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    // entries survive reset, so show the slot that a pop right after release takes
    if (sys_rst)
    begin
      rd_data <= mem_q[DEPTH-1];
    end
    else
    begin
      rd_data <= rd_data_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end
endmodule : return_stack_mem

// *** pc_stack_indirect_addr.sv ***
// program counter, circular return stack and indirect address former
// What this block does
// - keeps 13-bit program counter; low byte read/write, upper five from latch.
// - any reset clears the whole program counter to zero.
// - writing the low byte also loads bits 12..8 from the latch.
// - call loads bits 10..0 from operand, bits 12..11 from latch 4..3.
// - jump forms counter like call: operand plus latch bits 4..3.
// - eight by 13-bit return stack, pointer hidden from software.
// - push counter plus one on call, the counter itself on interrupt vectoring.
// - pop top entry into counter on return, literal return, interrupt return.
// - pushes and pops never change the high latch.
// - stack is circular; ninth push overwrites the first entry.
// - no overflow or underflow flag; excess pushes and pops are silent.
// - indirect port is no register; accesses go to pointed location.
// - indirect read that resolves to the port itself returns zero.
// - indirect write that resolves to the port itself stores nothing.
// - indirect address is bank bit above the 8-bit pointer.
// - high latch is a 5-bit buffer; upper read bits are zero.
`timescale 1ns/1ps
module pc_stack_indirect_addr
  import pc_stack_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire pc_op_type             pc_op,
  input  wire logic [10:0]           operand,
  input  wire logic [PC_WIDTH-1:0]   vector_addr,
  input  wire logic [7:0]            low_byte_wdata,
  input  wire logic                  latch_we,
  input  wire logic [7:0]            latch_wdata,
  input  wire logic                  pointer_we,
  input  wire logic [7:0]            pointer_wdata,
  input  wire logic                  indirect_bank_bit,
  input  wire logic                  data_access,
  input  wire logic                  data_write,
  input  wire logic [7:0]            data_file_addr,
  input  wire logic [7:0]            mem_rdata,
  output logic      [PC_WIDTH-1:0]   pc,
  output logic      [7:0]            pc_low_byte_reg,
  output logic      [7:0]            pc_high_latch,
  output logic      [7:0]            indirect_pointer_reg,
  output logic      [ADDR_WIDTH-1:0] data_addr,
  output logic                       data_write_en,
  output logic      [7:0]            data_rdata
);
  logic [PC_WIDTH-1:0]        pc_q, pc_d;
  logic [LATCH_WIDTH-1:0]     latch_q, latch_d;
  logic [7:0]                 pointer_q, pointer_d;
  logic [STACK_PTR_WIDTH-1:0] sp_q, sp_d;
  logic [PC_WIDTH-1:0]        top_entry;
  logic                       push;
  logic                       pop;
  logic                       via_pointer;
  logic                       self_ref;
  logic [ADDR_WIDTH-1:0]      addr_d, addr_q;
  logic                       we_d, we_q;
  logic                       self_rd_d, self_rd_q;

  // program counter and stack pointer next state
  always_comb
  begin
    pc_d = pc_q;
    sp_d = sp_q;
    push = 1'b0;
    pop  = 1'b0;
    unique case (pc_op)
      PC_HOLD:      pc_d = pc_q;
      PC_STEP:      pc_d = pc_q + 13'h0001;
      PC_WRITE_LOW: pc_d = {latch_q, low_byte_wdata};
      PC_CALL:
      begin
        pc_d = {latch_q[4:3], operand};
        push = 1'b1;
      end
      PC_JUMP:      pc_d = {latch_q[4:3], operand};
      PC_VECTOR:
      begin
        pc_d = vector_addr;
        push = 1'b1;
      end
      PC_RETURN:
      begin
        pc_d = top_entry;
        pop  = 1'b1;
      end
      // code 7 is never issued; treat it as hold so the stack stays untouched
      default:      pc_d = pc_q;
    endcase
    // pointer wraps freely with no flag, so deep nesting loses old frames
    if (push)
    begin
      sp_d = sp_q + 3'h1;
    end
    else if (pop)
    begin
      sp_d = sp_q - 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pc_q <= PC_RESET;
      sp_q <= '0;
    end
    else
    begin
      pc_q <= pc_d;
      sp_q <= sp_d;
    end
  end

  // return address is the counter of the pushing instruction plus one for a call, the counter itself for vectoring
  return_stack_mem #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_WIDTH)
  ) u_stack (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (push),
    .wr_addr (sp_q),
    .wr_data (pc_op == PC_VECTOR ? pc_q : pc_q + 13'h0001),
    .rd_addr (sp_d - 3'h1),
    .rd_data (top_entry)
  );

  // high latch and indirect pointer; stack traffic never touches the latch
  always_comb
  begin
    latch_d   = latch_q;
    pointer_d = pointer_q;
    if (latch_we)
    begin
      latch_d = latch_wdata[LATCH_WIDTH-1:0];
    end
    if (pointer_we)
    begin
      pointer_d = pointer_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      latch_q   <= LATCH_RESET;
      pointer_q <= POINTER_RESET;
    end
    else
    begin
      latch_q   <= latch_d;
      pointer_q <= pointer_d;
    end
  end

  // indirect access resolution
  always_comb
  begin
    via_pointer = (data_file_addr == INDIRECT_REG_ADDR);
    self_ref    = via_pointer && (pointer_q == INDIRECT_REG_ADDR);
    addr_d      = via_pointer ? {indirect_bank_bit, pointer_q}
                              : {indirect_bank_bit, data_file_addr};
    we_d        = data_access && data_write && !self_ref;
    self_rd_d   = data_access && self_ref;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      addr_q    <= '0;
      we_q      <= 1'b0;
      self_rd_q <= 1'b0;
    end
    else
    begin
      addr_q    <= addr_d;
      we_q      <= we_d;
      self_rd_q <= self_rd_d;
    end
  end

  assign pc                   = pc_q;
  assign pc_low_byte_reg      = pc_q[7:0];
  assign pc_high_latch        = {3'h0, latch_q};
  assign indirect_pointer_reg = pointer_q;
  assign data_addr            = addr_q;
  assign data_write_en        = we_q;
  assign data_rdata           = self_rd_q ? READ_SELF_VALUE : mem_rdata;

  a_reset_clears: assert property (@(posedge clk) sys_rst |=> pc == 13'h0000)
    else $error("pc not cleared by reset");
  a_low_write_load: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_WRITE_LOW |=> pc == {$past(latch_q), $past(low_byte_wdata)})
    else $error("low byte write did not load all bits");
  a_call_target: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_CALL |=> pc == {$past(latch_q[4:3]), $past(operand)})
    else $error("call target wrong");
  a_jump_target: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_JUMP |=> pc == {$past(latch_q[4:3]), $past(operand)})
    else $error("jump high bits wrong");
  a_call_return: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_CALL ##1 pc_op == PC_RETURN |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return address mismatch");
  a_latch_stable: assert property (@(posedge clk) disable iff (sys_rst)
    (push || pop) && !latch_we |=> $stable(latch_q))
    else $error("stack traffic changed latch");
  a_ptr_wraps: assert property (@(posedge clk) disable iff (sys_rst)
    push ##1 push [*7] |=> sp_q == $past(sp_q, 8))
    else $error("stack pointer not circular");
  a_self_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
    self_rd_d |=> data_rdata == 8'h00)
    else $error("self indirect read not zero");
  a_self_write_nop: assert property (@(posedge clk) disable iff (sys_rst)
    self_ref |=> !data_write_en)
    else $error("self indirect write stored");
  a_bank_address: assert property (@(posedge clk) disable iff (sys_rst)
    via_pointer |=> data_addr == {$past(indirect_bank_bit), $past(pointer_q)})
    else $error("indirect address wrong");

  // counter, stack traffic, reset state, latch, pointer and the indirect path, one cycle after each request
  a_step_count: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_STEP
    |=> pc == $past(pc) + 13'h0001)
    else $error("step did not advance by one");
  a_hold_keeps: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_HOLD
    |=> $stable(pc))
    else $error("counter moved on hold");
  a_reset_state: assert property (@(posedge clk)
    sys_rst
    |=> pc_high_latch == 8'h00 && indirect_pointer_reg == 8'h00 && !data_write_en)
    else $error("latch, pointer or write enable not cleared by reset");
  a_vector_target: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_VECTOR
    |=> pc == $past(vector_addr))
    else $error("vector target wrong");
  a_vector_push: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_VECTOR
    |=> top_entry == $past(pc))
    else $error("vectoring pushed wrong counter");
  a_vector_return: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_VECTOR ##1 pc_op == PC_RETURN
    |=> pc == $past(pc, 2))
    else $error("interrupt return address mismatch");
  a_call_push: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_CALL
    |=> top_entry == $past(pc) + 13'h0001)
    else $error("call pushed wrong return address");
  a_jump_no_push: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_JUMP
    |=> $stable(sp_q))
    else $error("jump moved the stack pointer");
  a_pop_restore: assert property (@(posedge clk) disable iff (sys_rst)
    pc_op == PC_RETURN
    |=> pc == $past(top_entry))
    else $error("pop did not restore the stacked counter");
  a_pop_step: assert property (@(posedge clk) disable iff (sys_rst)
    pop
    |=> sp_q == $past(sp_q) - 3'h1)
    else $error("pop did not step the pointer back");
  a_latch_load: assert property (@(posedge clk) disable iff (sys_rst)
    latch_we
    |=> pc_high_latch == {3'h0, $past(latch_wdata[4:0])})
    else $error("high latch not loaded as written");
  a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !latch_we
    |=> $stable(latch_q))
    else $error("high latch changed without a write");
  a_pointer_load: assert property (@(posedge clk) disable iff (sys_rst)
    pointer_we
    |=> indirect_pointer_reg == $past(pointer_wdata))
    else $error("pointer not loaded");
  a_pointer_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !pointer_we
    |=> $stable(pointer_q))
    else $error("pointer changed without a write");
  a_read_pass: assert property (@(posedge clk) disable iff (sys_rst)
    data_access && !self_ref
    |=> data_rdata == mem_rdata)
    else $error("read data not passed through");
  a_direct_address: assert property (@(posedge clk) disable iff (sys_rst)
    data_access && !via_pointer
    |=> data_addr == {$past(indirect_bank_bit), $past(data_file_addr)})
    else $error("direct address wrong");
  a_write_pass: assert property (@(posedge clk) disable iff (sys_rst)
    data_access && data_write && !self_ref
    |=> data_write_en)
    else $error("ordinary write suppressed");
  a_idle_no_write: assert property (@(posedge clk) disable iff (sys_rst)
    !data_access
    |=> !data_write_en)
    else $error("write enable without access");

  // scenarios the bench must reach
  c_call_return: cover property (@(posedge clk) pc_op == PC_CALL ##[1:5] pc_op == PC_RETURN);
  c_vector: cover property (@(posedge clk) pc_op == PC_VECTOR);
  c_self_ref: cover property (@(posedge clk) data_access && self_ref);
  c_stack_wrap: cover property (@(posedge clk) push [*8] ##1 push);
  c_self_write: cover property (@(posedge clk) data_access && data_write && self_ref);
endmodule : pc_stack_indirect_addr

// *** data_mem_model.sv ***
// data memory stand-in that answers reads at the resolved address
`timescale 1ns/1ps
module data_mem_model
(
  input  wire logic [8:0] addr,
  output logic      [7:0] rdata
);
  // the pattern depends on every address bit, so a wrong or stale address shows up unless bits 7 and 8 are both wrong
  assign rdata = addr[7:0] ^ {addr[8], 7'h5A};
endmodule : data_mem_model

// *** tb.sv ***
// self-checking bench: program counter, return stack, indirect addressing
`timescale 1ns/1ps
module tb;
  import pc_stack_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  pc_op_type   pc_op = PC_HOLD;
  pc_op_type   o_r;
  logic [10:0] operand = 11'h000;
  logic [12:0] vector_addr = 13'h0000;
  logic [7:0]  low_byte_wdata = 8'h00;
  logic        latch_we = 1'b0;
  logic [7:0]  latch_wdata = 8'h00;
  logic        pointer_we = 1'b0;
  logic [7:0]  pointer_wdata = 8'h00;
  logic        indirect_bank_bit = 1'b0;
  logic        data_access = 1'b0;
  logic        data_write = 1'b0;
  logic [7:0]  data_file_addr = 8'h00;
  logic [7:0]  mem_rdata, pc_low_byte_reg, pc_high_latch, indirect_pointer_reg, data_rdata;
  logic [12:0] pc, e_pc, np;
  logic [12:0] stk [8];
  logic [8:0]  data_addr, e_addr;
  logic [4:0]  e_lat;
  logic [7:0]  e_ptr;
  logic [2:0]  sp;
  logic        data_write_en, selfref;
  logic [31:0] r, q;
  integer      error_cnt = 0, n_compared = 0, seed = 23;
  // pulse requests for the next op; op drives each pulse pin once per cycle
  logic        lw = 1'b0, pw = 1'b0, da = 1'b0;

  pc_stack_indirect_addr DUT (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .pc_op                (pc_op),
    .operand              (operand),
    .vector_addr          (vector_addr),
    .low_byte_wdata       (low_byte_wdata),
    .latch_we             (latch_we),
    .latch_wdata          (latch_wdata),
    .pointer_we           (pointer_we),
    .pointer_wdata        (pointer_wdata),
    .indirect_bank_bit    (indirect_bank_bit),
    .data_access          (data_access),
    .data_write           (data_write),
    .data_file_addr       (data_file_addr),
    .mem_rdata            (mem_rdata),
    .pc                   (pc),
    .pc_low_byte_reg      (pc_low_byte_reg),
    .pc_high_latch        (pc_high_latch),
    .indirect_pointer_reg (indirect_pointer_reg),
    .data_addr            (data_addr),
    .data_write_en        (data_write_en),
    .data_rdata           (data_rdata)
  );
  data_mem_model mem (.addr(data_addr), .rdata(mem_rdata));

  always #5 clk = ~clk;

  function automatic logic [7:0] mem_val(input logic [8:0] a);
    return a[7:0] ^ {a[8], 7'h5A};
  endfunction : mem_val

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // inputs were set at a falling edge; predict, let one rising edge pass, compare
  task automatic cyc;
    selfref = data_file_addr == INDIRECT_REG_ADDR && e_ptr == INDIRECT_REG_ADDR;
    e_addr = {indirect_bank_bit, data_file_addr == INDIRECT_REG_ADDR ? e_ptr : data_file_addr};
    case (pc_op)
      PC_STEP:      np = e_pc + 13'h0001;
      PC_WRITE_LOW: np = {e_lat, low_byte_wdata};
      PC_CALL:      np = {e_lat[4:3], operand};
      PC_JUMP:      np = {e_lat[4:3], operand};
      PC_VECTOR:    np = vector_addr;
      PC_RETURN:    np = stk[sp - 3'h1];
      default:      np = e_pc;
    endcase
    if (pc_op == PC_CALL || pc_op == PC_VECTOR)
    begin
      stk[sp] = pc_op == PC_CALL ? e_pc + 13'h0001 : e_pc;
      sp = sp + 3'h1;
    end
    if (pc_op == PC_RETURN)
      sp = sp - 3'h1;
    if (latch_we)
      e_lat = latch_wdata[4:0];
    if (pointer_we)
      e_ptr = pointer_wdata;
    e_pc = np;
    if (sys_rst)
    begin
      e_pc = PC_RESET;
      e_lat = LATCH_RESET;
      e_ptr = POINTER_RESET;
      sp = 3'h0;
    end
    @(negedge clk);
    chk(pc, e_pc);
    chk(pc_low_byte_reg, e_pc[7:0]);
    chk(pc_high_latch, e_lat);
    chk(indirect_pointer_reg, e_ptr);
    chk(data_write_en, data_access && data_write && !selfref && !sys_rst);
    if (data_access && !sys_rst)
      chk(data_addr, e_addr);
    if (data_access && !data_write && !sys_rst)
      chk(data_rdata, selfref ? READ_SELF_VALUE : mem_val(e_addr));
  endtask : cyc

  task automatic op(input pc_op_type o, input logic [12:0] v);
    pc_op = o;
    operand = v[10:0];
    vector_addr = v;
    low_byte_wdata = v[7:0];
    latch_we = lw;
    pointer_we = pw;
    data_access = da;
    cyc();
    lw = 1'b0;
    pw = 1'b0;
    da = 1'b0;
  endtask : op

  task automatic lat(input logic [7:0] v);
    lw = 1'b1;
    latch_wdata = v;
    op(PC_HOLD, 13'h0000);
  endtask : lat

  task automatic acc(input logic [7:0] p, fa, input logic wr, bk);
    pw = 1'b1;
    pointer_wdata = p;
    op(PC_HOLD, 13'h0000);
    da = 1'b1;
    data_write = wr;
    data_file_addr = fa;
    indirect_bank_bit = bk;
    op(PC_STEP, 13'h0000);
  endtask : acc

  initial
  begin
    repeat (20) cyc();
    sys_rst = 1'b0;
    lat(8'hFF);
    op(PC_WRITE_LOW, 13'h00AA);
    op(PC_JUMP, 13'h07FF);
    op(PC_STEP, 13'h0000);
    lat(8'h0E);
    op(PC_WRITE_LOW, 13'h00FF);
    lat(8'h0F);
    op(PC_WRITE_LOW, 13'h0000);
    for (int i = 0; i < 10; i++)
      op(PC_CALL, 13'(i * 197));
    for (int i = 0; i < 10; i++)
      op(PC_RETURN, 13'h0000);
    op(PC_VECTOR, 13'h1234);
    op(PC_RETURN, 13'h0000);
    for (int i = 0; i < 4; i++)
      acc(i[1] ? 8'h40 : 8'h00, 8'h00, i[0], i[1]);
    acc(8'h41, 8'h25, 1'b0, 1'b1);
    // bank bit stays low while the pointer is zero: mirrored self addresses are left open
    repeat (2)
    begin
      repeat (1500)
      begin
        r = $random(seed);
        q = $random(seed);
        o_r = pc_op_type'(r[31:29] % 3'd7);
        da = q[0];
        data_write = q[1];
        data_file_addr = q[2] ? 8'h00 : q[15:8];
        indirect_bank_bit = q[3] && e_ptr != 8'h00;
        pw = q[4] && !q[0];
        pointer_wdata = {q[23:17], 1'b1};
        latch_wdata = r[28:21];
        lw = r[20] && !(o_r inside {PC_WRITE_LOW, PC_CALL, PC_JUMP});
        op(o_r, r[12:0]);
      end
      sys_rst = 1'b1;
      op(PC_HOLD, 13'h0000);
      sys_rst = 1'b0;
    end
    stop_test();
  end

  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule : tb
